// ---- design/pdb_params.svh ----
// constants of the pci dma burst engine: addresses, fields, codes
`ifndef PDB_PARAMS_SVH
`define PDB_PARAMS_SVH
// apb register addresses
`define PDB_ADDR_CFG 32'h8000_0400
`define PDB_ADDR_IOWIN 32'h8000_0414
`define PDB_ADDR_CTRL 32'h8000_0500
`define PDB_ADDR_AHB 32'h8000_0504
`define PDB_ADDR_PCI 32'h8000_0508
`define PDB_ADDR_LEN 32'h8000_050C
// control/status fields
`define PDB_CS_GO 0
`define PDB_CS_DIR 1
`define PDB_CS_RDY 2
`define PDB_CS_ERR 3
`define PDB_CS_KIND 7:4
// configuration/status fields
`define PDB_CF_MEMWIN 31:30
`define PDB_CF_LAT 22:15
`define PDB_CF_WERR 14
`define PDB_CF_HOST 13
`define PDB_CF_BM 12
`define PDB_CF_MS 11
`define PDB_CF_WB 10
`define PDB_CF_RB 9
`define PDB_CF_CTO 8
`define PDB_CF_CLS 7:0
`define PDB_IOWIN 31:16
`define PDB_LEN 11:0
`define PDB_MEM_LOW 29:0
`define PDB_IO_LOW 15:0
`define PDB_KB_LOW 9:0
// cycle kinds and pci commands
`define PDB_KIND_IO 4'h4
`define PDB_KIND_MEM 4'h8
`define PDB_CMD_IOR 4'h2
`define PDB_CMD_IOW 4'h3
`define PDB_CMD_MRM 4'hC
`define PDB_CMD_MRL 4'hE
`define PDB_CMD_MW 4'h7
`define PDB_CMD_MWI 4'hF
// ahb codes and steps
`define PDB_TRANS_IDLE 2'h0
`define PDB_TRANS_NONSEQ 2'h2
`define PDB_RESP_OKAY 2'h0
`define PDB_SIZE_WORD 3'h2
`define PDB_WORD_STEP 32'h0000_0004
`define PDB_LEN_ONE 12'h001
`define PDB_ZERO 32'h0000_0000
`endif

// ---- design/pdb_pkg.sv ----
// types of the pci dma burst engine
package pdb_pkg;
  typedef enum logic [2:0] {
    PDB_IDLE = 3'b000,
    PDB_AADDR = 3'b001,
    PDB_ADATA = 3'b010,
    PDB_PREQ = 3'b011,
    PDB_PWAIT = 3'b100,
    PDB_GAP = 3'b101
  } pdb_state_t;

  // configuration-space mirrors coming from the pci unit
  typedef struct packed {
    logic [7:0] lat;
    logic [7:0] line;
    logic bus_master;
    logic mem_space;
    logic host_n;
    logic wr_err;
    logic cfg_to;
  } pdb_cfg_t;

  typedef struct packed {
    pdb_state_t state;
    logic go_bit;
    logic direction_sel;
    logic [3:0] cycle_kind;
    logic err;
    logic rdy;
    logic abort;
    logic [31:0] ahb_addr;
    logic [31:0] pci_addr;
    logic [11:0] word_count;
    logic [1:0] mem_window_upper;
    logic wr_burst_cmd_sel;
    logic rd_burst_cmd_sel;
    logic [15:0] io_window_upper;
    logic [31:0] prdata;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic req_tgl;
    logic [3:0] req_cmd;
    logic [31:0] req_data;
    logic ack_s1;
    logic ack_s2;
    logic ack_seen;
    pdb_cfg_t cfg_s1;
    pdb_cfg_t cfg_s2;
    logic bypass;
    logic [31:0] bp_pci_addr;
  } pdb_sys_t;

  typedef struct packed {
    logic rq_s1;
    logic rq_s2;
    logic rq_seen;
    logic req;
    logic ack_tgl;
    logic err;
    logic [31:0] rdata;
  } pdb_link_t;
endpackage : pdb_pkg

// ---- design/pdb_dma.sv ----
// pci dma burst engine: apb registers, ahb side, pci master handshake
//
// Contract
// - memory cycles map pci address as window bits over ahb address bits 29:0.
// - configuration register shows the latency timer mirror, read only.
// - target write error flag reads one after a failed target write.
// - host role flag reads one when the unit is system host.
// - bus master and memory space enables mirrored read only.
// - write bursts use memory write, or write and invalidate when selected.
// - read bursts use read multiple, or read line when selected.
// - configuration timeout flag reads one after a timeout.
// - low byte shows cache line size mirror; writes do not change it.
// - i/o cycles map pci address as window bits over ahb bits 15:0.
// - data moves through the pci master interface of the unit.
// - only full 32-bit words move.
// - any error aborts the transfer at once and sets the fault flag.
// - no deadlock detection; software may abort a running transfer.
// - bursts are split at 1 kB ahb boundaries by idle cycles.
// - ahb slave port is bypassed straight through while idle.
// - control, ahb address, pci address, length sit at consecutive words.
// - kind 0100b selects i/o cycles, 1000b selects memory cycles.
// - writing one to the go bit starts the transfer.
// - twelve-bit length counts 32-bit words.
// - fault flag stays set until software writes one to it.
`timescale 1ns/1ns
`include "pdb_params.svh"

module pdb_dma (
  // system clock and reset
  input logic clk,
  input logic resetn,
  // apb slave
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [31:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  // ahb master toward system memory
  output logic [1:0] htrans,
  output logic [31:0] haddr,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input logic hready,
  input logic [1:0] hresp,
  input logic [31:0] hrdata,
  // bypass path of the pci unit slave port
  input logic bp_io,
  input logic [31:0] bp_haddr,
  output logic [31:0] bp_pci_addr,
  output logic bypass,
  // configuration-space mirrors from the pci unit (asynchronous levels)
  input pdb_pkg::pdb_cfg_t cfg_in,
  // pci master request port, on the link clock
  input logic pci_clk,
  output logic pm_req,
  output logic pm_write,
  output logic [3:0] pm_cmd,
  output logic [31:0] pm_addr,
  output logic [31:0] pm_wdata,
  input logic pm_done,
  input logic pm_err,
  input logic [31:0] pm_rdata
);
  pdb_pkg::pdb_sys_t s;
  pdb_pkg::pdb_sys_t next_s;
  pdb_pkg::pdb_link_t l;
  pdb_pkg::pdb_link_t next_l;
  logic [1:0] rst_sync;
  logic [1:0] prst_sync;

  // window mapping for the bypassed slave path
  function automatic logic [31:0] map_addr(input logic io, input logic [31:0] a,
                                           input logic [1:0] mw, input logic [15:0] iw);
    if (io) begin
      map_addr = {iw, a[`PDB_IO_LOW]};
    end else begin
      map_addr = {mw, a[`PDB_MEM_LOW]};
    end
  endfunction : map_addr

  // pci command for the programmed kind and direction
  function automatic logic [3:0] pick_cmd(input logic [3:0] kind, input logic dir,
                                          input logic wb, input logic rb);
    if (kind == `PDB_KIND_IO) begin
      pick_cmd = dir ? `PDB_CMD_IOW : `PDB_CMD_IOR;
    end else if (dir) begin
      pick_cmd = wb ? `PDB_CMD_MWI : `PDB_CMD_MW;
    end else begin
      pick_cmd = rb ? `PDB_CMD_MRL : `PDB_CMD_MRM;
    end
  endfunction : pick_cmd

  // ==========================================================
  // reset release, one synchroniser per domain
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  always_ff @(posedge pci_clk or negedge resetn) begin
    if (!resetn) begin
      prst_sync <= 2'h0;
    end else begin
      prst_sync <= {prst_sync[0], 1'b1};
    end
  end

  // ==========================================================
  // system domain: registers and transfer sequencer
  always_comb begin
    logic wr;
    logic rd;
    logic start;
    logic word_done;
    logic fail;
    logic set_rdy;
    logic set_err;
    logic [31:0] rv;
    wr = psel && penable && pwrite;
    rd = psel && !penable && !pwrite;
    start = 1'b0;
    word_done = 1'b0;
    fail = 1'b0;
    set_rdy = 1'b0;
    set_err = 1'b0;
    rv = `PDB_ZERO;
    next_s = s;
    // level mirrors pass two flops before anything reads them
    next_s.cfg_s1 = cfg_in;
    next_s.cfg_s2 = s.cfg_s1;
    next_s.ack_s1 = l.ack_tgl;
    next_s.ack_s2 = s.ack_s1;
    next_s.bp_pci_addr = map_addr(bp_io, bp_haddr, s.mem_window_upper, s.io_window_upper);

    // read data captured in the setup phase so it leaves a flop
    case (paddr)
      `PDB_ADDR_CFG: begin
        rv[`PDB_CF_MEMWIN] = s.mem_window_upper;
        rv[`PDB_CF_LAT] = s.cfg_s2.lat;
        rv[`PDB_CF_WERR] = s.cfg_s2.wr_err;
        rv[`PDB_CF_HOST] = !s.cfg_s2.host_n;
        rv[`PDB_CF_BM] = s.cfg_s2.bus_master;
        rv[`PDB_CF_MS] = s.cfg_s2.mem_space;
        rv[`PDB_CF_WB] = s.wr_burst_cmd_sel;
        rv[`PDB_CF_RB] = s.rd_burst_cmd_sel;
        rv[`PDB_CF_CTO] = s.cfg_s2.cfg_to;
        rv[`PDB_CF_CLS] = s.cfg_s2.line;
      end
      `PDB_ADDR_IOWIN: rv[`PDB_IOWIN] = s.io_window_upper;
      `PDB_ADDR_CTRL: begin
        rv[`PDB_CS_KIND] = s.cycle_kind;
        rv[`PDB_CS_ERR] = s.err;
        rv[`PDB_CS_RDY] = s.rdy;
        rv[`PDB_CS_DIR] = s.direction_sel;
        rv[`PDB_CS_GO] = s.go_bit;
      end
      `PDB_ADDR_AHB: rv = s.ahb_addr;
      `PDB_ADDR_PCI: rv = s.pci_addr;
      `PDB_ADDR_LEN: rv[`PDB_LEN] = s.word_count;
      default: rv = `PDB_ZERO;
    endcase
    if (rd) begin
      next_s.prdata = rv;
    end

    // register writes; direction, kind, addresses and length are frozen while a transfer runs
    if (wr) begin
      case (paddr)
        `PDB_ADDR_CFG: begin
          next_s.mem_window_upper = pwdata[`PDB_CF_MEMWIN];
          next_s.wr_burst_cmd_sel = pwdata[`PDB_CF_WB];
          next_s.rd_burst_cmd_sel = pwdata[`PDB_CF_RB];
        end
        `PDB_ADDR_IOWIN: next_s.io_window_upper = pwdata[`PDB_IOWIN];
        `PDB_ADDR_CTRL: begin
          if (pwdata[`PDB_CS_ERR]) begin
            next_s.err = 1'b0;
          end
          if (pwdata[`PDB_CS_RDY]) begin
            next_s.rdy = 1'b0;
          end
          if (!s.go_bit) begin
            next_s.direction_sel = pwdata[`PDB_CS_DIR];
            next_s.cycle_kind = pwdata[`PDB_CS_KIND];
            start = pwdata[`PDB_CS_GO];
          end else if (!pwdata[`PDB_CS_GO]) begin
            next_s.abort = 1'b1;
          end
        end
        `PDB_ADDR_AHB: if (!s.go_bit) next_s.ahb_addr = pwdata;
        `PDB_ADDR_PCI: if (!s.go_bit) next_s.pci_addr = pwdata;
        `PDB_ADDR_LEN: if (!s.go_bit) next_s.word_count = pwdata[`PDB_LEN];
        default: ;
      endcase
    end

    // sequencer: one word at a time, ahb and pci sides alternate
    case (s.state)
      pdb_pkg::PDB_IDLE: begin
        if (start) begin
          if (pwdata[`PDB_CS_KIND] != `PDB_KIND_IO && pwdata[`PDB_CS_KIND] != `PDB_KIND_MEM) begin
            set_err = 1'b1;
          end else if (s.word_count == 12'h000) begin
            set_rdy = 1'b1;
          end else begin
            next_s.go_bit = 1'b1;
            next_s.abort = 1'b0;
            next_s.state = pwdata[`PDB_CS_DIR] ? pdb_pkg::PDB_AADDR : pdb_pkg::PDB_PREQ;
          end
        end
      end
      pdb_pkg::PDB_AADDR: begin
        next_s.htrans = `PDB_TRANS_NONSEQ;
        next_s.hwrite = !s.direction_sel;
        next_s.hsize = `PDB_SIZE_WORD;
        if (hready && s.htrans == `PDB_TRANS_NONSEQ) begin
          next_s.htrans = `PDB_TRANS_IDLE;
          next_s.hwdata = s.req_data;
          next_s.state = pdb_pkg::PDB_ADATA;
        end
      end
      pdb_pkg::PDB_ADATA: begin
        if (hready) begin
          if (hresp != `PDB_RESP_OKAY) begin
            fail = 1'b1;
          end else if (s.direction_sel) begin
            next_s.req_data = hrdata;
            next_s.state = pdb_pkg::PDB_PREQ;
          end else begin
            word_done = 1'b1;
          end
        end
      end
      pdb_pkg::PDB_PREQ: begin
        next_s.req_cmd = pick_cmd(s.cycle_kind, s.direction_sel,
                                  s.wr_burst_cmd_sel, s.rd_burst_cmd_sel);
        next_s.req_tgl = !s.req_tgl;
        next_s.state = pdb_pkg::PDB_PWAIT;
      end
      pdb_pkg::PDB_PWAIT: begin
        if (s.ack_s2 != s.ack_seen) begin
          next_s.ack_seen = s.ack_s2;
          if (l.err) begin
            fail = 1'b1;
          end else if (s.direction_sel) begin
            word_done = 1'b1;
          end else begin
            next_s.req_data = l.rdata; // stable: the link side holds it until the next request
            next_s.state = pdb_pkg::PDB_AADDR;
          end
        end
      end
      pdb_pkg::PDB_GAP: begin
        // one idle ahb cycle before the burst resumes past the boundary
        next_s.state = s.direction_sel ? pdb_pkg::PDB_AADDR : pdb_pkg::PDB_PREQ;
      end
      default: next_s.state = pdb_pkg::PDB_IDLE;
    endcase

    // word bookkeeping; addresses stay on the failing word after an error
    if (word_done) begin
      next_s.word_count = s.word_count - `PDB_LEN_ONE;
      next_s.ahb_addr = s.ahb_addr + `PDB_WORD_STEP;
      next_s.pci_addr = s.pci_addr + `PDB_WORD_STEP;
      if (s.word_count == `PDB_LEN_ONE) begin
        set_rdy = 1'b1;
        next_s.go_bit = 1'b0;
        next_s.state = pdb_pkg::PDB_IDLE;
      end else if (s.abort || next_s.abort) begin
        next_s.go_bit = 1'b0;
        next_s.state = pdb_pkg::PDB_IDLE;
      end else if (next_s.ahb_addr[`PDB_KB_LOW] == 10'h000) begin
        next_s.state = pdb_pkg::PDB_GAP;
      end else begin
        next_s.state = s.direction_sel ? pdb_pkg::PDB_AADDR : pdb_pkg::PDB_PREQ;
      end
    end
    if (fail) begin
      set_err = 1'b1;
      next_s.go_bit = 1'b0;
      next_s.htrans = `PDB_TRANS_IDLE;
      next_s.state = pdb_pkg::PDB_IDLE;
    end

    // hardware set wins over a software clear in the same cycle
    if (set_rdy) begin
      next_s.rdy = 1'b1;
    end
    if (set_err) begin
      next_s.err = 1'b1;
    end
    next_s.bypass = (next_s.state == pdb_pkg::PDB_IDLE);
  end

  always_ff @(posedge clk or negedge rst_sync[1]) begin
    if (!rst_sync[1]) begin
      s <= '0;
      s.bypass <= 1'b1;
      s.hsize <= `PDB_SIZE_WORD;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // link domain: request toggle in, pulse-free level handshake to the unit
  always_comb begin
    next_l = l;
    next_l.rq_s1 = s.req_tgl;
    next_l.rq_s2 = l.rq_s1;
    if (!l.req && l.rq_s2 != l.rq_seen) begin
      next_l.req = 1'b1;
      next_l.rq_seen = l.rq_s2;
    end else if (l.req && pm_done) begin
      next_l.req = 1'b0;
      next_l.err = pm_err;
      next_l.rdata = pm_rdata;
      next_l.ack_tgl = !l.ack_tgl;
    end
  end

  always_ff @(posedge pci_clk or negedge prst_sync[1]) begin
    if (!prst_sync[1]) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end

  // outputs; pm_* request fields are held stable while a request is in flight
  assign prdata = s.prdata;
  assign htrans = s.htrans;
  assign haddr = s.ahb_addr;
  assign hwrite = s.hwrite;
  assign hsize = s.hsize;
  assign hwdata = s.hwdata;
  assign bp_pci_addr = s.bp_pci_addr;
  assign bypass = s.bypass;
  assign pm_req = l.req;
  assign pm_write = s.direction_sel;
  assign pm_cmd = s.req_cmd;
  assign pm_addr = s.pci_addr;
  assign pm_wdata = s.req_data;

  // ==========================================================
  // checks
  property p_mem_map;
    @(posedge clk) disable iff (!rst_sync[1])
      !bp_io |=> s.bp_pci_addr == {$past(s.mem_window_upper), $past(bp_haddr[`PDB_MEM_LOW])};
  endproperty
  a_mem_map: assert property (p_mem_map) else $error("memory window map wrong");

  property p_mirror;
    @(posedge clk) disable iff (!rst_sync[1])
      ##2 s.cfg_s2 == $past(cfg_in, 2);
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror latency wrong");

  property p_wr_cmd;
    @(posedge clk) disable iff (!rst_sync[1])
      (s.state == pdb_pkg::PDB_PREQ && s.cycle_kind == `PDB_KIND_MEM && s.direction_sel)
      |=> s.req_cmd == ($past(s.wr_burst_cmd_sel) ? `PDB_CMD_MWI : `PDB_CMD_MW);
  endproperty
  a_wr_cmd: assert property (p_wr_cmd) else $error("write burst command wrong");

  property p_rd_cmd;
    @(posedge clk) disable iff (!rst_sync[1])
      (s.state == pdb_pkg::PDB_PREQ && s.cycle_kind == `PDB_KIND_MEM && !s.direction_sel)
      |=> s.req_cmd == ($past(s.rd_burst_cmd_sel) ? `PDB_CMD_MRL : `PDB_CMD_MRM);
  endproperty
  a_rd_cmd: assert property (p_rd_cmd) else $error("read burst command wrong");

  property p_abort_err;
    @(posedge clk) disable iff (!rst_sync[1])
      (s.state == pdb_pkg::PDB_ADATA && hready && hresp != `PDB_RESP_OKAY)
      |=> s.err && s.state == pdb_pkg::PDB_IDLE && !s.go_bit ##1 s.htrans == `PDB_TRANS_IDLE;
  endproperty
  a_abort_err: assert property (p_abort_err) else $error("error did not abort");

  property p_gap;
    @(posedge clk) disable iff (!rst_sync[1])
      s.state == pdb_pkg::PDB_GAP |-> s.htrans == `PDB_TRANS_IDLE && s.ahb_addr[`PDB_KB_LOW] == 10'h000;
  endproperty
  a_gap: assert property (p_gap) else $error("boundary gap misplaced");

  property p_bypass;
    @(posedge clk) disable iff (!rst_sync[1])
      s.bypass == (s.state == pdb_pkg::PDB_IDLE);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass not tied to idle");

  property p_err_sticky;
    @(posedge clk) disable iff (!rst_sync[1])
      (s.err && !(psel && penable && pwrite && paddr == `PDB_ADDR_CTRL && pwdata[`PDB_CS_ERR]))
      |=> s.err;
  endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("fault flag dropped");

  property p_link_hs;
    @(posedge pci_clk) disable iff (!prst_sync[1])
      (l.req && pm_done) |=> !l.req && l.ack_tgl != $past(l.ack_tgl);
  endproperty
  a_link_hs: assert property (p_link_hs) else $error("link handshake broken");
endmodule : pdb_dma

// ---- tb/pdb_pci_target.sv ----
// pci target model on the link clock, answering the engine's master requests
`timescale 1ns/1ns

module pdb_pci_target (
  // link clock
  input logic pci_clk,
  // master request from the engine
  input logic pm_req,
  input logic pm_write,
  input logic [3:0] pm_cmd,
  input logic [31:0] pm_addr,
  input logic [31:0] pm_wdata,
  // completion toward the engine
  output logic pm_done,
  output logic pm_err,
  output logic [31:0] pm_rdata
);
  // ==========================================
  // request log and scenario knobs
  logic [3:0] cmd_log[$];
  logic [31:0] addr_log[$];
  logic [31:0] data_log[$];
  logic wr_log[$];
  int delay = 1;
  logic fail = 1'b0;
  int cnt = 0;

  initial begin
    pm_done = 1'b0;
    pm_err = 1'b0;
    pm_rdata = 32'h0000_0000;
  end

  // one word per request; read data scrambles outside the done cycle so stale
  // values never look valid
  always @(posedge pci_clk) begin
    if (pm_req && !pm_done && cnt >= delay) begin
      pm_done <= 1'b1;
      pm_err <= fail;
      pm_rdata <= pm_addr ^ 32'h5A5A_5A5A;
      cmd_log.push_back(pm_cmd);
      addr_log.push_back(pm_addr);
      data_log.push_back(pm_wdata);
      wr_log.push_back(pm_write);
      cnt <= 0;
    end else begin
      pm_done <= 1'b0;
      pm_err <= 1'b0;
      pm_rdata <= ~pm_rdata;
      cnt <= (pm_req && !pm_done) ? cnt + 1 : 0;
    end
  end
endmodule : pdb_pci_target

// ---- tb/pdb_dma_test.sv ----
// testbench of the pci dma burst engine
`timescale 1ns/1ns
`include "pdb_params.svh"

module pdb_dma_test;
  // ==========================================
  // nets, clocks and instances
  logic clk = 1'b0;
  logic pci_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, haddr, hwdata, bp_pci_addr, pm_addr, pm_wdata, pm_rdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hwrite, bypass, pm_req, pm_write, pm_done, pm_err;
  logic [3:0] pm_cmd;
  logic hready = 1'b1;
  logic [1:0] hresp = 2'h0;
  logic [31:0] hrdata = 32'h0000_0000;
  logic bp_io = 1'b0;
  logic [31:0] bp_haddr = 32'h0000_0000;
  pdb_pkg::pdb_cfg_t cfg_in = 21'h0;
  logic dph = 1'b0;
  logic [31:0] daddr = 32'h0000_0000;
  logic ahb_wait = 1'b0;
  logic ahb_fail = 1'b0;
  logic [31:0] adr_log[$];
  logic [31:0] wr_log[$];
  int cyc = 0;
  int size_bad = 0;
  int fail_count = 0;
  int n_checks = 0;

  always #10 clk = ~clk;
  // link clock with a phase unrelated to the system clock
  initial begin
    #37;
    forever #80 pci_clk = ~pci_clk;
  end

  pdb_dma uut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .htrans(htrans),
    .haddr(haddr), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hresp(hresp), .hrdata(hrdata), .bp_io(bp_io), .bp_haddr(bp_haddr),
    .bp_pci_addr(bp_pci_addr), .bypass(bypass), .cfg_in(cfg_in), .pci_clk(pci_clk),
    .pm_req(pm_req), .pm_write(pm_write), .pm_cmd(pm_cmd), .pm_addr(pm_addr),
    .pm_wdata(pm_wdata), .pm_done(pm_done), .pm_err(pm_err), .pm_rdata(pm_rdata));

  pdb_pci_target tgt (.pci_clk(pci_clk), .pm_req(pm_req), .pm_write(pm_write),
    .pm_cmd(pm_cmd), .pm_addr(pm_addr), .pm_wdata(pm_wdata), .pm_done(pm_done),
    .pm_err(pm_err), .pm_rdata(pm_rdata));

  // ahb memory answers at the falling edge; may stall every other cycle or fail
  always @(negedge clk) begin
    hready <= ahb_wait ? ~hready : 1'b1;
    hresp <= ahb_fail ? 2'h1 : 2'h0;
    hrdata <= daddr ^ 32'hC3C3_0000;
  end

  // ahb monitor and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (dph && hready) begin
      if (hwrite) wr_log.push_back(hwdata);
      dph <= 1'b0;
    end
    if (htrans == `PDB_TRANS_NONSEQ && hready) begin
      adr_log.push_back(haddr);
      dph <= 1'b1;
      daddr <= haddr;
      if (hsize !== `PDB_SIZE_WORD) size_bad++;
    end
    if (cyc == 40000) begin
      fail_count++;
      finish_test();
    end
  end

  // ==========================================
  // bus tasks and comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] q);
    @(negedge clk);
    psel = 1'b1;
    pwrite = wr;
    paddr = a;
    pwdata = d;
    @(negedge clk);
    penable = 1'b1;
    @(negedge clk);
    q = prdata;
    psel = 1'b0;
    penable = 1'b0;
  endtask : apb

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input string msg);
    logic [31:0] q;
    apb(1'b0, a, 32'h0000_0000, q);
    chk(q, exp, msg);
  endtask : rd_chk

  task automatic start_dma(input logic dir, input logic [3:0] kind, input logic [31:0] aa,
      input logic [31:0] pa, input logic [11:0] len);
    adr_log.delete();
    wr_log.delete();
    tgt.cmd_log.delete();
    tgt.addr_log.delete();
    tgt.data_log.delete();
    tgt.wr_log.delete();
    wr(`PDB_ADDR_CTRL, 32'h0000_000C);
    wr(`PDB_ADDR_AHB, aa);
    wr(`PDB_ADDR_PCI, pa);
    wr(`PDB_ADDR_LEN, {20'h0, len});
    wr(`PDB_ADDR_CTRL, {24'h0, kind, 2'b00, dir, 1'b1});
  endtask : start_dma

  // polls the go bit, which reads busy, under a bounded count
  task automatic wait_dma(output logic [31:0] cs);
    int i;
    cs = 32'h0000_0001;
    for (i = 0; i < 400 && cs[0] === 1'b1; i++) apb(1'b0, `PDB_ADDR_CTRL, 32'h0, cs);
  endtask : wait_dma

  // ==========================================
  // scenarios
  task automatic reg_test();
    cfg_in = {8'h5A, 8'h3C, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    wr(`PDB_ADDR_CFG, 32'hFFFF_FFFF);
    rd_chk(`PDB_ADDR_CFG, {2'b11, 7'h0, 8'h5A, 7'b1110110, 8'h3C}, "cfg a");
    cfg_in = {8'hA5, 8'hC3, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
    wr(`PDB_ADDR_CFG, 32'h0000_0000);
    rd_chk(`PDB_ADDR_CFG, {2'b00, 7'h0, 8'hA5, 7'b0001001, 8'hC3}, "cfg b");
    wr(`PDB_ADDR_IOWIN, 32'hFFFF_FFFF);
    rd_chk(`PDB_ADDR_IOWIN, 32'hFFFF_0000, "iowin");
    wr(`PDB_ADDR_LEN, 32'hFFFF_FFFF);
    rd_chk(`PDB_ADDR_LEN, 32'h0000_0FFF, "len");
    wr(`PDB_ADDR_AHB, 32'h1234_5678);
    wr(`PDB_ADDR_PCI, 32'h9ABC_DEF0);
    rd_chk(`PDB_ADDR_AHB, 32'h1234_5678, "ahb reg");
    rd_chk(`PDB_ADDR_PCI, 32'h9ABC_DEF0, "pci reg");
    wr(`PDB_ADDR_CTRL, 32'hFFFF_FF00);
    rd_chk(`PDB_ADDR_CTRL, 32'h0000_0000, "ctrl rsvd");
    rd_chk(32'h8000_0510, 32'h0000_0000, "unmapped");
    $display("test registers done");
  endtask : reg_test

  task automatic bypass_test();
    wr(`PDB_ADDR_CFG, 32'h8000_0000);
    wr(`PDB_ADDR_IOWIN, 32'hBEEF_0000);
    bp_haddr = 32'hC123_4568;
    repeat (3) @(negedge clk);
    chk({31'h0, bypass}, 32'h0000_0001, "idle bypass");
    chk(bp_pci_addr, 32'h8123_4568, "mem map");
    bp_io = 1'b1;
    bp_haddr = 32'hFFF0_1234;
    repeat (3) @(negedge clk);
    chk(bp_pci_addr, 32'hBEEF_1234, "io map");
    $display("test bypass done");
  endtask : bypass_test

  task automatic xfer_test(input logic dir, input logic [3:0] kind, input logic sel,
      input logic [3:0] cmd, input logic [31:0] aa, input logic [11:0] len);
    logic [31:0] cs;
    logic [31:0] a;
    int k;
    tgt.delay = dir ? 0 : 5;
    ahb_wait = ~dir;
    size_bad = 0;
    wr(`PDB_ADDR_CFG, {21'h0, sel, sel, 9'h0});
    start_dma(dir, kind, aa, 32'h1000_0040, len);
    wait_dma(cs);
    chk(cs, {24'h0, kind, 2'b01, dir, 1'b0}, "done");
    chk(32'(tgt.cmd_log.size()), {20'h0, len}, "words");
    chk(tgt.addr_log[0], 32'h1000_0040, "pci start");
    chk(32'(size_bad), 32'h0, "size");
    if (dir) chk(32'(wr_log.size()), 32'h0, "ahb read only");
    for (k = 0; k < len; k++) begin
      a = aa + 32'(4 * k);
      chk({28'h0, tgt.cmd_log[k]}, {28'h0, cmd}, "cmd");
      chk({31'h0, tgt.wr_log[k]}, {31'h0, dir}, "pci dir");
      chk(adr_log[k], a, "ahb addr");
      if (dir) chk(tgt.data_log[k], a ^ 32'hC3C3_0000, "to pci");
      else chk(wr_log[k], tgt.addr_log[k] ^ 32'h5A5A_5A5A, "to ahb");
    end
    wr(`PDB_ADDR_CTRL, 32'h0000_0004);
    rd_chk(`PDB_ADDR_CTRL, 32'h0000_0000, "ready clear");
    ahb_wait = 1'b0;
    $display("test transfer done");
  endtask : xfer_test

  // mode 0: target abort, mode 1: ahb error, mode 2: unknown cycle kind
  task automatic err_test(input int mode);
    logic [31:0] cs;
    logic [3:0] kind;
    kind = (mode == 2) ? 4'h1 : `PDB_KIND_MEM;
    tgt.fail = (mode == 0);
    ahb_fail = (mode == 1);
    start_dma(1'b1, kind, 32'h4000_0100, 32'h2000_0000, 12'h004);
    wait_dma(cs);
    tgt.fail = 1'b0;
    ahb_fail = 1'b0;
    chk(cs, {24'h0, kind, 4'b1010}, "fault");
    chk(32'(tgt.cmd_log.size()), (mode == 0) ? 1 : 0, "stopped");
    repeat (20) @(negedge clk);
    rd_chk(`PDB_ADDR_CTRL, {24'h0, kind, 4'b1010}, "fault held");
    wr(`PDB_ADDR_CTRL, 32'h0000_0008);
    rd_chk(`PDB_ADDR_CTRL, 32'h0000_0000, "fault clear");
    $display("test error done");
  endtask : err_test

  task automatic abort_test();
    logic [31:0] cs;
    tgt.delay = 12;
    start_dma(1'b1, `PDB_KIND_MEM, 32'h4000_0200, 32'h3000_0000, 12'h008);
    repeat (100) @(negedge clk);
    chk({31'h0, bypass}, 32'h0000_0000, "busy bypass");
    wr(`PDB_ADDR_CTRL, 32'h0000_0082);
    wait_dma(cs);
    chk(cs, 32'h0000_0082, "aborted");
    chk(32'(tgt.cmd_log.size() < 8), 32'h0000_0001, "cut short");
    $display("test abort done");
  endtask : abort_test

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  // ==========================================
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    repeat (8) @(negedge clk);
    reg_test();
    bypass_test();
    xfer_test(1'b1, `PDB_KIND_MEM, 1'b0, `PDB_CMD_MW, 32'h4000_0000, 12'h004);
    xfer_test(1'b1, `PDB_KIND_MEM, 1'b1, `PDB_CMD_MWI, 32'h4000_0000, 12'h004);
    xfer_test(1'b0, `PDB_KIND_MEM, 1'b0, `PDB_CMD_MRM, 32'h4000_0000, 12'h004);
    xfer_test(1'b0, `PDB_KIND_MEM, 1'b1, `PDB_CMD_MRL, 32'h4000_0000, 12'h004);
    xfer_test(1'b1, `PDB_KIND_IO, 1'b0, `PDB_CMD_IOW, 32'h4000_0000, 12'h003);
    xfer_test(1'b0, `PDB_KIND_IO, 1'b0, `PDB_CMD_IOR, 32'h4000_0000, 12'h003);
    xfer_test(1'b1, `PDB_KIND_MEM, 1'b0, `PDB_CMD_MW, 32'h4000_03F8, 12'h004);
    xfer_test(1'b0, `PDB_KIND_MEM, 1'b0, `PDB_CMD_MRM, 32'h4000_0800, 12'h001);
    err_test(0);
    err_test(1);
    err_test(2);
    abort_test();
    finish_test();
  end
endmodule : pdb_dma_test
